// ### ecir_pkg.sv
// Constants, field positions and types for the Ethernet controller register bank.
//
// Function
// [RULE1] Ring base pointers keep bits 0-29; bits 30-31 are dropped and read zero.
// [RULE2] Buffer size keeps bits 21-27 only; bits 28-31 forced zero; frames max 2047.
// [RULE3] Received frame check sequence always lands in the frame's final receive buffer.
// [RULE4] Software programs buffer size at least 0x5f0, preferably not below 256 bytes.
// [RULE5] Software sets pin-multiplex enable plus chip pin multiplexing for the controller.
// [RULE6] Enable allows traffic; clearing it ends a frame in progress with bad CRC.
// [RULE7] Clearing enable resets DMA, descriptor and FIFO control including their pointers.
// [RULE8] After enable clears, descriptors of the aborted transmit frame are not updated.
// [RULE9] Writing local reset clears enable, resets controller registers, aborts transfers.
// [RULE10] Local reset bit clears itself after about 16 clock cycles.
// [RULE11] Interrupt request asserts while any flagged event is also enabled by mask.
// [RULE12] Event flags clear by writing one; writing zero leaves them alone.
// [RULE13] Every event is flagged regardless of mask; mask only gates the request and the pending class.
// [RULE14] Software should mask per-buffer events and use per-frame events instead.
// [RULE15] Event 0 sets when heartbeat checking is on and heartbeat is missing.
// [RULE16] Event 1 sets on oversize receive frame; receive frames truncate above 2047.
// [RULE17] Event 2 sets on oversize transmit frame; transmit frames are never truncated.
// [RULE18] Event 3 sets when the frame in progress at graceful stop request finishes.
// [RULE19] Events 4 and 6 per frame done; events 5 and 7 per descriptor update.
// [RULE20] Event 8 on management transfer done; event 9 on internal bus error.
// [RULE21] Vector register bits 0-2 select interrupt level 0 to 7.
// [RULE22] Vector bits 28-29 report highest pending class: none, other, transmit, receive.
// [RULE23] Pending class counts flagged and unmasked events only; returns to none when cleared.
`default_nettype none
package ecir_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // Register byte addresses.
    localparam logic [11:0] ADDR_RX_RING_BASE = 12'he10;
    localparam logic [11:0] ADDR_TX_RING_BASE = 12'he14;
    localparam logic [11:0] ADDR_RX_BUFFER_LENGTH = 12'he18;
    localparam logic [11:0] ADDR_ETHERNET_CONTROL = 12'he40;
    localparam logic [11:0] ADDR_IRQ_EVENT_FLAGS = 12'he44;
    localparam logic [11:0] ADDR_IRQ_ENABLE_BITS = 12'he48;
    localparam logic [11:0] ADDR_IRQ_LEVEL_AND_CLASS = 12'he4c;
    ////////////////////////////////////////////////////////////////////////////////
    // Field positions, counted from bit 0 as the least significant bit of the bus word.
    localparam int RING_LSB = 2;
    localparam int BUFLEN_LSB = 4;
    localparam int BUFLEN_MSB = 10;
    localparam int CTRL_LOCAL_RESET_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int CTRL_PIN_SELECT_BIT = 2;
    localparam int LEVEL_LSB = 29;
    localparam int CLASS_LSB = 2;
    localparam int NUM_EVENTS = 10;
    ////////////////////////////////////////////////////////////////////////////////
    // Event numbers as the flag register numbers them (number n sits at bus bit 31-n).
    localparam int EV_HEARTBEAT_MISSING = 0;
    localparam int EV_RX_OVERSIZE = 1;
    localparam int EV_TX_OVERSIZE = 2;
    localparam int EV_GRACEFUL_STOP_DONE = 3;
    localparam int EV_TX_FRAME_DONE = 4;
    localparam int EV_TX_BUFFER_DONE = 5;
    localparam int EV_RX_FRAME_DONE = 6;
    localparam int EV_RX_BUFFER_DONE = 7;
    localparam int EV_MGMT_DONE = 8;
    localparam int EV_SYSTEM_BUS_ERROR = 9;
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, limits and timing.
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [2:0] RESET_LEVEL = 3'h0;
    localparam logic [10:0] MAX_FRAME_BYTES = 11'h7ff;
    localparam int CLOCK_HZ = 10_000_000;
    localparam int LOCAL_RESET_CYCLES = 16;
    localparam logic [4:0] LOCAL_RESET_COUNT = 5'(LOCAL_RESET_CYCLES);
    ////////////////////////////////////////////////////////////////////////////////
    // Pending interrupt class encodings.
    typedef enum logic [1:0] {
        ECIR_CLASS_NONE = 2'h0,
        ECIR_CLASS_OTHER = 2'h1,
        ECIR_CLASS_TX = 2'h2,
        ECIR_CLASS_RX = 2'h3
    } ecir_class_t;
endpackage
`default_nettype wire

// ### ecir_regs.sv
// Register bank of the Ethernet controller: ring bases, buffer size, control, events, mask, vector.
//
// Chosen here: register access over APB.
`default_nettype none
module ecir_regs
    import ecir_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events from the controller datapath, one-cycle pulses; heartbeat_check and tx_frame_active are levels.
    input wire logic heartbeat_check,
    input wire logic heartbeat_missing,
    input wire logic rx_oversize,
    input wire logic tx_oversize,
    input wire logic graceful_stop_request,
    input wire logic tx_frame_active,
    input wire logic tx_frame_done,
    input wire logic tx_buffer_done,
    input wire logic rx_frame_done,
    input wire logic rx_buffer_done,
    input wire logic mgmt_done,
    input wire logic system_bus_error,
    // Configuration to the controller datapath.
    output logic [29:0] rx_ring_start,
    output logic [29:0] tx_ring_start,
    output logic [6:0] rx_buffer_units,
    output logic [10:0] rx_max_frame,
    output logic rx_fcs_to_buffer,
    output logic pin_function_select,
    output logic controller_enable,
    output logic controller_reset,
    output logic tx_abort_bad_crc,
    output logic tx_descriptor_hold,
    // Interrupt.
    output logic irq_request,
    output logic [2:0] irq_level
);
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Event n is carried on bus bit 31-n.
    function automatic logic [31:0] pack_events(input logic [NUM_EVENTS-1:0] ev);
        logic [31:0] w;
        w = RESET_WORD;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            w[31-i] = ev[i];
        end
        return w;
    endfunction

    function automatic logic [NUM_EVENTS-1:0] unpack_events(input logic [31:0] w);
        logic [NUM_EVENTS-1:0] ev;
        ev = '0;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            ev[i] = w[31-i];
        end
        return ev;
    endfunction

    // Receive outranks transmit, which outranks the rest.
    function automatic ecir_class_t class_of(input logic [NUM_EVENTS-1:0] live);
        ecir_class_t c;
        c = ECIR_CLASS_NONE;
        if (live[EV_MGMT_DONE] || live[EV_SYSTEM_BUS_ERROR]) begin
            c = ECIR_CLASS_OTHER;
        end
        if (live[EV_HEARTBEAT_MISSING] || live[EV_TX_OVERSIZE] || live[EV_GRACEFUL_STOP_DONE]
            || live[EV_TX_FRAME_DONE] || live[EV_TX_BUFFER_DONE]) begin
            c = ECIR_CLASS_TX;
        end
        if (live[EV_RX_OVERSIZE] || live[EV_RX_FRAME_DONE] || live[EV_RX_BUFFER_DONE]) begin
            c = ECIR_CLASS_RX;
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic setup_phase;
    logic wr_commit;
    logic addr_mapped;
    logic [NUM_EVENTS-1:0] event_flags;
    logic [NUM_EVENTS-1:0] event_mask;
    logic [NUM_EVENTS-1:0] event_in;
    logic [NUM_EVENTS-1:0] next_event_flags;
    logic [NUM_EVENTS-1:0] live_events;
    logic [4:0] reset_count;
    logic local_reset_busy;
    logic graceful_pending;
    logic graceful_seen_request;
    logic [31:0] next_prdata;

    assign setup_phase = psel && !penable;
    // A write lands at the access edge, where pready is already high.
    assign wr_commit = psel && penable && pready && pwrite && addr_mapped;
    assign live_events = event_flags & event_mask;

    always_comb begin
        case (paddr)
            ADDR_RX_RING_BASE, ADDR_TX_RING_BASE, ADDR_RX_BUFFER_LENGTH, ADDR_ETHERNET_CONTROL,
            ADDR_IRQ_EVENT_FLAGS, ADDR_IRQ_ENABLE_BITS, ADDR_IRQ_LEVEL_AND_CLASS: begin
                addr_mapped = 1'b1;
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_prdata = RESET_WORD;
        case (paddr)
            ADDR_RX_RING_BASE: begin
                next_prdata[31:RING_LSB] = rx_ring_start; // RULE1
            end
            ADDR_TX_RING_BASE: begin
                next_prdata[31:RING_LSB] = tx_ring_start; // RULE1
            end
            ADDR_RX_BUFFER_LENGTH: begin
                next_prdata[BUFLEN_MSB:BUFLEN_LSB] = rx_buffer_units; // RULE2
            end
            ADDR_ETHERNET_CONTROL: begin
                next_prdata[CTRL_PIN_SELECT_BIT] = pin_function_select;
                next_prdata[CTRL_ENABLE_BIT] = controller_enable;
                next_prdata[CTRL_LOCAL_RESET_BIT] = local_reset_busy;
            end
            ADDR_IRQ_EVENT_FLAGS: begin
                next_prdata = pack_events(event_flags);
            end
            ADDR_IRQ_ENABLE_BITS: begin
                next_prdata = pack_events(event_mask);
            end
            ADDR_IRQ_LEVEL_AND_CLASS: begin
                next_prdata[31:LEVEL_LSB] = irq_level;
                next_prdata[CLASS_LSB+1:CLASS_LSB] = class_of(live_events); // RULE22 RULE23
            end
            default: begin
                next_prdata = RESET_WORD;
            end
        endcase
    end

    // One wait-free access phase: answer is prepared during setup so outputs stay registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RESET_WORD;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !addr_mapped;
            if (setup_phase) begin
                prdata <= (pwrite || !addr_mapped) ? RESET_WORD : next_prdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ring bases and buffer size; untouched by the local reset.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ring_start <= '0;
            tx_ring_start <= '0;
            rx_buffer_units <= '0;
        end else if (wr_commit) begin
            if (paddr == ADDR_RX_RING_BASE) begin
                rx_ring_start <= pwdata[31:RING_LSB]; // RULE1
            end
            if (paddr == ADDR_TX_RING_BASE) begin
                tx_ring_start <= pwdata[31:RING_LSB]; // RULE1
            end
            if (paddr == ADDR_RX_BUFFER_LENGTH) begin
                rx_buffer_units <= pwdata[BUFLEN_MSB:BUFLEN_LSB]; // RULE2
            end
        end
    end

    // The datapath truncates receive frames at this length and keeps the check sequence.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_max_frame <= MAX_FRAME_BYTES; // RULE16
            rx_fcs_to_buffer <= 1'b1; // RULE3
        end else begin
            rx_max_frame <= MAX_FRAME_BYTES; // RULE16
            rx_fcs_to_buffer <= 1'b1; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register and local reset sequencer.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_count <= '0;
            local_reset_busy <= 1'b0;
        end else if (local_reset_busy) begin
            if (reset_count == 5'h01) begin
                local_reset_busy <= 1'b0; // RULE10
            end
            reset_count <= reset_count - 5'h01;
        end else if (wr_commit && paddr == ADDR_ETHERNET_CONTROL && pwdata[CTRL_LOCAL_RESET_BIT]) begin
            local_reset_busy <= 1'b1; // RULE9
            reset_count <= LOCAL_RESET_COUNT; // RULE10
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            controller_enable <= 1'b0;
            pin_function_select <= 1'b0;
        end else if (local_reset_busy
                     || (wr_commit && paddr == ADDR_ETHERNET_CONTROL && pwdata[CTRL_LOCAL_RESET_BIT])) begin
            controller_enable <= 1'b0; // RULE9
            pin_function_select <= 1'b0; // RULE9
        end else if (wr_commit && paddr == ADDR_ETHERNET_CONTROL) begin
            controller_enable <= pwdata[CTRL_ENABLE_BIT]; // RULE6
            pin_function_select <= pwdata[CTRL_PIN_SELECT_BIT];
        end
    end

    // Disabling ends the frame in progress with a bad CRC, resets DMA and FIFO control
    // and freezes the descriptors of the aborted frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            controller_reset <= 1'b1;
            tx_abort_bad_crc <= 1'b0;
            tx_descriptor_hold <= 1'b1;
        end else begin
            controller_reset <= !controller_enable || local_reset_busy; // RULE7 RULE9
            tx_abort_bad_crc <= controller_reset == 1'b0 && (!controller_enable || local_reset_busy)
                                && tx_frame_active; // RULE6
            tx_descriptor_hold <= !controller_enable; // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Graceful stop tracking: done once the frame active at the request has left.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            graceful_seen_request <= 1'b0;
            graceful_pending <= 1'b0;
        end else if (local_reset_busy) begin
            graceful_seen_request <= 1'b0;
            graceful_pending <= 1'b0;
        end else begin
            graceful_seen_request <= graceful_stop_request;
            if (graceful_stop_request && !graceful_seen_request) begin
                graceful_pending <= 1'b1;
            end else if (graceful_pending && !tx_frame_active) begin
                graceful_pending <= 1'b0; // RULE18
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event flags, mask and interrupt.

    always_comb begin
        event_in = '0;
        event_in[EV_HEARTBEAT_MISSING] = heartbeat_check && heartbeat_missing; // RULE15
        event_in[EV_RX_OVERSIZE] = rx_oversize; // RULE16
        event_in[EV_TX_OVERSIZE] = tx_oversize; // RULE17
        event_in[EV_GRACEFUL_STOP_DONE] = graceful_pending && !tx_frame_active; // RULE18
        event_in[EV_TX_FRAME_DONE] = tx_frame_done; // RULE19
        event_in[EV_TX_BUFFER_DONE] = tx_buffer_done; // RULE19
        event_in[EV_RX_FRAME_DONE] = rx_frame_done; // RULE19
        event_in[EV_RX_BUFFER_DONE] = rx_buffer_done; // RULE19
        event_in[EV_MGMT_DONE] = mgmt_done; // RULE20
        event_in[EV_SYSTEM_BUS_ERROR] = system_bus_error; // RULE20
    end

    always_comb begin
        next_event_flags = event_flags;
        if (wr_commit && paddr == ADDR_IRQ_EVENT_FLAGS) begin
            next_event_flags = event_flags & ~unpack_events(pwdata); // RULE12
        end
        // A new event wins over a clear in the same cycle, whatever the mask.
        next_event_flags = next_event_flags | event_in; // RULE13
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_flags <= '0;
        end else if (local_reset_busy) begin
            event_flags <= '0; // RULE9
        end else begin
            event_flags <= next_event_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_mask <= '0;
            irq_level <= RESET_LEVEL;
        end else if (local_reset_busy) begin
            event_mask <= '0; // RULE9
            irq_level <= RESET_LEVEL; // RULE9
        end else if (wr_commit) begin
            if (paddr == ADDR_IRQ_ENABLE_BITS) begin
                event_mask <= unpack_events(pwdata);
            end
            if (paddr == ADDR_IRQ_LEVEL_AND_CLASS) begin
                irq_level <= pwdata[31:LEVEL_LSB]; // RULE21
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= |live_events; // RULE11 RULE13
        end
    end
endmodule
`default_nettype wire

// ### ecir_regs_checker.sv
// Port assertions for the Ethernet controller register bank, attached by bind.
`default_nettype none
module ecir_regs_checker
    import ecir_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Datapath side.
    input wire logic tx_frame_active,
    input wire logic [10:0] rx_max_frame,
    input wire logic rx_fcs_to_buffer,
    input wire logic controller_enable,
    input wire logic controller_reset,
    input wire logic tx_abort_bad_crc,
    input wire logic tx_descriptor_hold
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_local_reset;
        psel && penable && pready && pwrite && paddr == ADDR_ETHERNET_CONTROL && pwdata[CTRL_LOCAL_RESET_BIT];
    endsequence
    sequence s_enable_drop;
        $fell(controller_enable) && tx_frame_active;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_local_reset_hold: assert property (s_local_reset |=> !controller_enable [*8])
        else $error("enable during local reset");
    a_reset_follows: assert property (!controller_enable |=> controller_reset)
        else $error("datapath not held in reset");
    a_descriptor_freeze: assert property ($fell(controller_enable) |=> tx_descriptor_hold)
        else $error("descriptors not frozen");
    a_abort_on_drop: assert property (s_enable_drop |-> ##[0:1] tx_abort_bad_crc)
        else $error("no bad crc abort");
    a_fixed_outputs: assert property (rx_max_frame == MAX_FRAME_BYTES && rx_fcs_to_buffer)
        else $error("frame limit or fcs placement wrong");
endmodule

bind ecir_regs ecir_regs_checker u_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .tx_frame_active(tx_frame_active), .rx_max_frame(rx_max_frame), .rx_fcs_to_buffer(rx_fcs_to_buffer),
    .controller_enable(controller_enable), .controller_reset(controller_reset),
    .tx_abort_bad_crc(tx_abort_bad_crc), .tx_descriptor_hold(tx_descriptor_hold)
);
`default_nettype wire

// ### ecir_host.sv
// Host model: APB master issuing one transfer at a time.
`default_nettype none
module ecir_host (
    // Clock.
    input wire logic pclk,
    // APB master.
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h0,
    output logic [31:0] pwdata = 32'h0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    // The request stays put until pready is seen high at a rising edge.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        @(negedge pclk);
    endtask
endmodule
`default_nettype wire

// ### ecir_regs_tb.sv
// Self-checking bench for the Ethernet controller register bank.
`default_nettype none
module ecir_regs_tb;
    import ecir_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic hb_chk = 1'b1;
    logic tx_act = 1'b0;
    logic [9:0] ev = 10'h0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [29:0] rx_ring_start, tx_ring_start;
    logic [6:0] rx_buffer_units;
    logic [10:0] rx_max_frame;
    logic [2:0] irq_level;
    logic rx_fcs_to_buffer, pin_function_select, controller_enable, controller_reset;
    logic tx_abort_bad_crc, tx_descriptor_hold, irq_request;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int aborts = 0;
    always #50 pclk = ~pclk;
    ecir_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ecir_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .heartbeat_check(hb_chk), .heartbeat_missing(ev[0]), .rx_oversize(ev[1]), .tx_oversize(ev[2]),
        .graceful_stop_request(ev[3]), .tx_frame_active(tx_act), .tx_frame_done(ev[4]),
        .tx_buffer_done(ev[5]), .rx_frame_done(ev[6]), .rx_buffer_done(ev[7]), .mgmt_done(ev[8]),
        .system_bus_error(ev[9]), .rx_ring_start(rx_ring_start), .tx_ring_start(tx_ring_start),
        .rx_buffer_units(rx_buffer_units), .rx_max_frame(rx_max_frame), .rx_fcs_to_buffer(rx_fcs_to_buffer),
        .pin_function_select(pin_function_select), .controller_enable(controller_enable),
        .controller_reset(controller_reset), .tx_abort_bad_crc(tx_abort_bad_crc),
        .tx_descriptor_hold(tx_descriptor_hold), .irq_request(irq_request), .irq_level(irq_level));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b0, a, 32'h0, r, e);
        chk("read", r, exp);
        chk("slverr", {31'h0, e}, 32'h0);
    endtask
    task automatic end_sim();
        $display("Checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("hold", {30'h0, controller_reset, tx_descriptor_hold}, 32'h3);
        rd(ADDR_ETHERNET_CONTROL, RESET_WORD);
        rd(ADDR_IRQ_EVENT_FLAGS, RESET_WORD);
        rd(ADDR_IRQ_ENABLE_BITS, RESET_WORD);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, RESET_WORD);
    endtask
    task automatic t_fields();
        wr(ADDR_RX_RING_BASE, 32'hffff_ffff);
        wr(ADDR_TX_RING_BASE, 32'h1234_5677);
        wr(ADDR_RX_BUFFER_LENGTH, 32'hffff_ffff);
        rd(ADDR_RX_RING_BASE, 32'hffff_fffc);
        rd(ADDR_TX_RING_BASE, 32'h1234_5674);
        rd(ADDR_RX_BUFFER_LENGTH, 32'h0000_07f0);
        chk("rxring", {2'h0, rx_ring_start}, 32'h3fff_ffff);
        chk("txring", {2'h0, tx_ring_start}, 32'h048d_159d);
        wr(ADDR_RX_BUFFER_LENGTH, 32'h0000_05f0);
        chk("units", {25'h0, rx_buffer_units}, 32'h5f);
        chk("fcs", {31'h0, rx_fcs_to_buffer}, 32'h1);
        chk("maxframe", {21'h0, rx_max_frame}, 32'h7ff);
    endtask
    task automatic t_events();
        @(posedge pclk);
        hb_chk <= 1'b0;
        ev <= 10'h1;
        @(posedge pclk);
        hb_chk <= 1'b1;
        ev <= 10'h0;
        rd(ADDR_IRQ_EVENT_FLAGS, RESET_WORD);
        for (int i = 0; i < NUM_EVENTS; i++) begin
            @(posedge pclk);
            ev <= 10'h1 << i;
            @(posedge pclk);
            ev <= 10'h0;
        end
        rd(ADDR_IRQ_EVENT_FLAGS, 32'hffc0_0000);
        chk("irq", {31'h0, irq_request}, 32'h0);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, 32'h0);
        wr(ADDR_IRQ_ENABLE_BITS, 32'h0200_0000);
        @(negedge pclk);
        chk("irq", {31'h0, irq_request}, 32'h1);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, 32'hc);
        wr(ADDR_IRQ_EVENT_FLAGS, 32'h0);
        rd(ADDR_IRQ_EVENT_FLAGS, 32'hffc0_0000);
        wr(ADDR_IRQ_EVENT_FLAGS, 32'h0200_0000);
        wr(ADDR_IRQ_ENABLE_BITS, 32'hffc0_0000);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, 32'hc);
        wr(ADDR_IRQ_EVENT_FLAGS, 32'h4100_0000);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, 32'h8);
        wr(ADDR_IRQ_EVENT_FLAGS, 32'hbc00_0000);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, 32'h4);
        wr(ADDR_IRQ_EVENT_FLAGS, 32'hffff_ffff);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, 32'h0);
        chk("irq", {31'h0, irq_request}, 32'h0);
    endtask
    task automatic t_control();
        @(posedge pclk);
        tx_act <= 1'b1;
        wr(ADDR_ETHERNET_CONTROL, 32'h6);
        @(negedge pclk);
        chk("enable", {30'h0, pin_function_select, controller_enable}, 32'h3);
        chk("hold", {30'h0, controller_reset, tx_descriptor_hold}, 32'h0);
        wr(ADDR_ETHERNET_CONTROL, 32'h4);
        @(negedge pclk);
        chk("hold", {30'h0, controller_reset, tx_descriptor_hold}, 32'h3);
        @(negedge pclk);
        chk("abort", aborts, 32'h1);
        wr(ADDR_IRQ_LEVEL_AND_CLASS, 32'hffff_ffff);
        rd(ADDR_IRQ_LEVEL_AND_CLASS, 32'he000_0000);
        chk("level", {29'h0, irq_level}, 32'h7);
    endtask
    task automatic t_local_reset();
        logic [31:0] r;
        logic e;
        wr(ADDR_ETHERNET_CONTROL, 32'h6);
        wr(ADDR_ETHERNET_CONTROL, 32'h1);
        rd(ADDR_ETHERNET_CONTROL, 32'h1);
        chk("enable", {31'h0, controller_enable}, 32'h0);
        repeat (16) @(posedge pclk);
        rd(ADDR_ETHERNET_CONTROL, 32'h0);
        chk("level", {29'h0, irq_level}, 32'h0);
        chk("abort", aborts, 32'h2);
        rd(ADDR_RX_RING_BASE, 32'hffff_fffc);
        u_host.xfer(1'b0, 12'he50, 32'h0, r, e);
        chk("unmapped", r, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cycles++;
        if (tx_abort_bad_crc === 1'b1) aborts++;
        if (cycles == 2000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_events();
        t_control();
        t_local_reset();
        end_sim();
    end
endmodule
`default_nettype wire
